// File: tick_pkg.sv
// package: register map, field layout, reset values and carriers of the tick unit
package tick_pkg;

   // ==========================================================
   // register map (byte addresses on the avalon word bus)
   localparam logic [3:0] COUNT_OFFSET  = 4'h0; // tick_counter_value
   localparam logic [3:0] CTRL_OFFSET   = 4'h4; // tick_control_status

   // ==========================================================
   // control/status field positions
   localparam int PRESCALE_LSB = 0;  // prescale_select [2:0]
   localparam int RUN_BIT      = 3;  // count_run_enable
   localparam int IRQ_EN_BIT   = 4;  // wrap_irq_enable
   localparam int WRAP_BIT     = 5;  // wrap_flag

   // ==========================================================
   // reset values
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET  = 8'h00;
   localparam logic [7:0] COUNT_MAX   = 8'hFF; // value before the wrap

   // ==========================================================
   // cpu power state as seen by the unit
   typedef enum logic [1:0] {
      PWR_RUN  = 2'b00,
      PWR_WAIT = 2'b01,
      PWR_HALT = 2'b11
   } pwr_state_e;

   // software-written control fields
   typedef struct packed {
      logic       irq_en;   // wrap_irq_enable
      logic       run;      // count_run_enable
      logic [2:0] psel;     // prescale_select
   } ctrl_s;

   // avalon request carrier
   typedef struct packed {
      logic [3:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } av_req_s;

endpackage : tick_pkg

// File: tick_prescaler.sv
// prescaler: free divider with selectable power-of-two tick output
`timescale 1ns/1ps
module tick_prescaler #(
   parameter int DIV_BITS = 8            // 2^DIV_BITS is the largest division
) (
   input  wire logic       clk,          // cpu clock
   input  wire logic       arst_n,       // async reset, active low
   input  wire logic       run,          // high lets the divider advance
   input  wire logic [2:0] psel,         // 0..7 selects divide 2..256
   output logic            tick          // one-cycle pulse per period
);

   initial begin
      if (DIV_BITS != 8) $error("tick_prescaler: DIV_BITS must be 8");
   end

   typedef struct packed {
      logic [DIV_BITS-1:0] div;          // divider chain
   } pre_s;

   pre_s st_ff;                          // registered state
   pre_s nxt_st;                         // next state
   logic [DIV_BITS-1:0] low_mask;        // bits that must all be one

   // ==========================================================
   // tick when the selected low bits are all set and running
   always_comb begin
      nxt_st   = st_ff;
      low_mask = DIV_BITS'((16'h0002 << psel) - 16'h0001);
      // a stopped unit keeps the divider cleared
      if (!run) begin
         nxt_st.div = '0;                                  // RULE_06
      end else begin
         nxt_st.div = st_ff.div + DIV_BITS'(1);            // RULE_06
      end
      tick = run && ((st_ff.div & low_mask) == low_mask);  // RULE_02
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule : tick_prescaler

// File: tick_sync.sv
// three-flop synchroniser with agreement filter for an outside level
`timescale 1ns/1ps
module tick_sync #(
   parameter int WIDTH = 2               // bits carried
) (
   input  wire logic             clk,    // cpu clock
   input  wire logic             arst_n, // async reset, active low
   input  wire logic [WIDTH-1:0] d,      // asynchronous level
   output logic      [WIDTH-1:0] q       // filtered level
);

   initial begin
      if (WIDTH < 1) $error("tick_sync: WIDTH must be positive");
   end

   typedef struct packed {
      logic [WIDTH-1:0] s1;              // first stage, read only by s2
      logic [WIDTH-1:0] s2;              // second stage
      logic [WIDTH-1:0] s3;              // third stage
      logic [WIDTH-1:0] out;             // accepted level
   } sync_s;

   sync_s st_ff;                         // registered state
   sync_s nxt_st;                        // next state

   // ==========================================================
   // a change counts once stages two and three agree
   always_comb begin
      nxt_st    = st_ff;
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st_ff.s2[i] == st_ff.s3[i]) begin
            nxt_st.out[i] = st_ff.s3[i];
         end
      end
      q = st_ff.out;
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule : tick_sync

// File: periodic_tick_unit.sv
// periodic tick unit: 8-bit prescaled up-counter with wrap flag and request
// Function
// [RULE_01] run enable starts counting from current value
// [RULE_02] increment per prescaler tick, divide 2..256
// [RULE_03] wrap from FF to 00 sets flag
// [RULE_04] request when flag and irq enable set
// [RULE_05] request ignores the cpu global mask
// [RULE_06] run low freezes counter, resets prescaler
// [RULE_07] reading control/status clears wrap flag
// [RULE_08] writes never change the wrap flag
// [RULE_09] counter writable any time, counting continues
// [RULE_10] counter eight bits, readable any time
// [RULE_11] control/status bits 7:6 read zero
// [RULE_12] both registers reset to zero
// [RULE_13] count in wait state, stop in halt
`timescale 1ns/1ps
module periodic_tick_unit (
   input  wire logic        clk,           // cpu clock, 100 MHz
   input  wire logic        arst_n,        // async reset, active low
   input  wire logic [3:0]  address,       // avalon byte address
   input  wire logic        read,          // avalon read strobe
   input  wire logic        write,         // avalon write strobe
   input  wire logic [31:0] writedata,     // avalon write data
   input  wire logic [3:0]  byteenable,    // avalon byte enables
   output logic      [31:0] readdata,      // avalon read data
   output logic             waitrequest,   // avalon stall
   output logic      [1:0]  response,      // 00 okay, 10 slave error
   input  wire logic [1:0]  cpu_pwr_state, // power state, async to us
   output logic             wrap_irq       // overflow request, level
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [7:0]          count;      // count_bits
      tick_pkg::ctrl_s     ctrl;       // software controls
      logic                wrap;       // wrap_flag
      logic                ack;        // answer phase of an access
      logic [31:0]         rdata;      // registered read data
      logic [1:0]          resp;       // registered response
   } unit_s;

   unit_s                 st_ff;       // registered state
   unit_s                 nxt_st;      // next state
   tick_pkg::av_req_s     req;         // bundled bus request
   logic [1:0]            pwr_sync;    // synchronised power state
   logic                  halted;      // cpu in halt
   logic                  pre_tick;    // prescaler output pulse
   logic                  count_en;    // counting allowed this cycle
   logic                  take;        // request accepted this edge
   logic                  hit_count;   // counter register addressed
   logic                  hit_ctrl;    // control register addressed
   logic                  wrap_now;    // increment crosses FF to 00

   assign req = '{address:    address,
                  read:       read,
                  write:      write,
                  writedata:  writedata,
                  byteenable: byteenable};

   // ==========================================================
   // power state comes from another domain, filter it
   tick_sync #(
      .WIDTH (2)
   ) u_pwr_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .d      (cpu_pwr_state),
      .q      (pwr_sync)
   );

   // halt stops the unit; wait leaves it running so it can wake the cpu
   assign halted   = (pwr_sync == tick_pkg::PWR_HALT);          // RULE_13
   assign count_en = st_ff.ctrl.run && !halted;                 // RULE_13

   // ==========================================================
   // prescaler: held in reset whenever counting is not allowed
   tick_prescaler #(
      .DIV_BITS (8)
   ) u_prescaler (
      .clk    (clk),
      .arst_n (arst_n),
      .run    (count_en),                                       // RULE_06
      .psel   (st_ff.ctrl.psel),                                // RULE_02
      .tick   (pre_tick)
   );

   // ==========================================================
   // bus decode: one wait cycle, then the answer edge
   always_comb begin
      take      = (req.read || req.write) && st_ff.ack;
      hit_count = 1'b0;
      hit_ctrl  = 1'b0;
      if (req.address == tick_pkg::COUNT_OFFSET) begin
         hit_count = 1'b1;
      end else if (req.address == tick_pkg::CTRL_OFFSET) begin
         hit_ctrl = 1'b1;
      end
   end

   // ==========================================================
   // next-state logic
   always_comb begin
      nxt_st   = st_ff;
      wrap_now = 1'b0;

      // ack rises one cycle after the request, falls after the edge taken
      if ((req.read || req.write) && !st_ff.ack) begin
         nxt_st.ack = 1'b1;
      end else begin
         nxt_st.ack = 1'b0;
      end

      // counting resumes from whatever value is held, no reload
      if (count_en && pre_tick) begin                           // RULE_01
         nxt_st.count = st_ff.count + 8'h01;                    // RULE_02
         wrap_now     = (st_ff.count == tick_pkg::COUNT_MAX);   // RULE_03
      end

      // read data is prepared during the wait cycle
      nxt_st.rdata = 32'h0000_0000;
      nxt_st.resp  = 2'b00;
      if (hit_count) begin
         nxt_st.rdata[7:0] = st_ff.count;                       // RULE_10
      end else if (hit_ctrl) begin
         nxt_st.rdata[tick_pkg::WRAP_BIT]   = st_ff.wrap;
         nxt_st.rdata[tick_pkg::IRQ_EN_BIT] = st_ff.ctrl.irq_en;
         nxt_st.rdata[tick_pkg::RUN_BIT]    = st_ff.ctrl.run;
         nxt_st.rdata[tick_pkg::PRESCALE_LSB +: 3] = st_ff.ctrl.psel;
         // bits 7:6 and above stay zero
         nxt_st.rdata[7:6] = 2'b00;                             // RULE_11
      end else begin
         nxt_st.resp = 2'b10;        // unmapped address answers slave error
      end

      // a write to the counter wins over the tick in the same cycle
      if (take && req.write && hit_count && req.byteenable[0]) begin
         nxt_st.count = req.writedata[7:0];                     // RULE_09
      end

      // control write: the flag bit of the data is ignored
      if (take && req.write && hit_ctrl && req.byteenable[0]) begin
         nxt_st.ctrl.irq_en = req.writedata[tick_pkg::IRQ_EN_BIT];
         nxt_st.ctrl.run    = req.writedata[tick_pkg::RUN_BIT];
         nxt_st.ctrl.psel   = req.writedata[tick_pkg::PRESCALE_LSB +: 3];
      end                                                       // RULE_08

      // read clears the flag only if the snapshot showed it set, so a wrap
      // that lands in the wait cycle is not lost; a wrap now still wins
      if (take && req.read && hit_ctrl &&
          st_ff.rdata[tick_pkg::WRAP_BIT]) begin
         nxt_st.wrap = 1'b0;                                    // RULE_07
      end
      if (wrap_now) begin
         nxt_st.wrap = 1'b1;                                    // RULE_03
      end
   end

   // ==========================================================
   // bus outputs: stall until the answer cycle
   assign waitrequest = !st_ff.ack;
   assign readdata    = st_ff.rdata;
   assign response    = st_ff.resp;

   // request is not gated by the cpu global mask; the cpu applies it
   assign wrap_irq = st_ff.wrap && st_ff.ctrl.irq_en;           // RULE_04 RULE_05

   // ==========================================================
   // state register; everything clears to zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff.count <= tick_pkg::COUNT_RESET;                  // RULE_12
         st_ff.ctrl  <= tick_pkg::CTRL_RESET[4:0];              // RULE_12
         st_ff.wrap  <= 1'b0;                                   // RULE_12
         st_ff.ack   <= 1'b0;
         st_ff.rdata <= 32'h0000_0000;
         st_ff.resp  <= 2'b00;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule : periodic_tick_unit

// File: tick_unit_props.sv
// checker: bus answer and request relations of the tick unit
`timescale 1ns/1ps
module tick_unit_props (
   input wire logic        clk,           // clock
   input wire logic        arst_n,        // reset, active low
   input wire logic [3:0]  address,       // address
   input wire logic        read,          // read strobe
   input wire logic        write,         // write strobe
   input wire logic [31:0] writedata,     // write data
   input wire logic [3:0]  byteenable,    // lanes
   input wire logic [31:0] readdata,      // read data
   input wire logic        waitrequest,   // stall
   input wire logic [1:0]  response,      // status
   input wire logic [1:0]  cpu_pwr_state, // power state
   input wire logic        wrap_irq       // wrap request
);
   // ===========================================================
   // helpers
   logic mapped; // one of the two registers
   assign mapped = (address == 4'h0) || (address == 4'h4);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // answer lasts exactly one cycle
   sequence answer_s;
      !waitrequest ##1 waitrequest;
   endsequence
   // control/status read being answered
   sequence ctrl_read_s;
      !waitrequest && read && address == 4'h4;
   endsequence
   // ===========================================================
   // assertions
   a_wait_single: assert property (
      $fell(waitrequest) |-> answer_s) else $error("answer not one cycle");
   a_wait_answer: assert property (
      (read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered in one cycle");
   a_ctrl_reserved: assert property (
      ctrl_read_s |-> readdata[31:6] == 26'h0) else $error("top bits set");
   a_count_width: assert property (
      !waitrequest && read && address == 4'h0 |-> readdata[31:8] == 24'h0)
      else $error("count wider than a byte");
   a_bad_addr: assert property (
      !waitrequest && !mapped |-> response == 2'b10 && (write || !readdata))
      else $error("unmapped access not refused");
   a_ok_resp: assert property (
      !waitrequest && mapped |-> response == 2'b00) else $error("bad status");
   a_irq_snap: assert property (
      ctrl_read_s |-> (readdata[5] && readdata[4]) == $past(wrap_irq))
      else $error("request differs from flag and enable");
   // only a control access may drop the request
   a_irq_falls: assert property (
      $fell(wrap_irq) |-> $past(!waitrequest && address == 4'h4))
      else $error("request dropped without control access");
endmodule : tick_unit_props

bind periodic_tick_unit tick_unit_props tick_unit_props_i (
   .clk(clk), .arst_n(arst_n), .address(address), .read(read),
   .write(write), .writedata(writedata), .byteenable(byteenable),
   .readdata(readdata), .waitrequest(waitrequest), .response(response),
   .cpu_pwr_state(cpu_pwr_state), .wrap_irq(wrap_irq));

// File: tb_top.sv
// testbench: bus driver and counting model for the tick unit
`timescale 1ns/1ps
module tb_top;
   // ===========================================================
   // stimulus and model state
   logic clk, arst_n, read, write, waitrequest, wrap_irq; // pins
   logic [3:0] address, byteenable;                       // bus
   logic [31:0] writedata, readdata, q;                   // data
   logic [1:0] response, r, cpu_pwr_state;                // status
   int mismatches, comparisons, cyc, tk, t1, g, d, inc, flag, start, en;
   periodic_tick_unit periodic_tick_unit_i (
      .clk(clk), .arst_n(arst_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .response(response),
      .cpu_pwr_state(cpu_pwr_state), .wrap_irq(wrap_irq));
   // clock and cycle count for measuring run time
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   // ===========================================================
   // closing, compare and bus tasks
   task report_and_stop;
      $display("compares %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : chk
   // request raised after an edge and held until the rising edge that
   // sees waitrequest low; the answer is taken and released at that edge
   task bus(input logic wr, input logic [3:0] a, input logic [7:0] dv);
      int n;
      @(posedge clk);
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= {24'h0, dv};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (waitrequest !== 1'b0) begin
         mismatches++;
         report_and_stop;
      end else begin
         q = readdata;
         r = response;
         tk = cyc;
         read <= 1'b0;
         write <= 1'b0;
      end
   endtask : bus
   // one run: load, start, wait, stop, then compare with the model
   task run_case(input int p, input logic [1:0] pw);
      d = 2 << p;
      start = $urandom % 256;
      en = $urandom % 2;
      cpu_pwr_state <= pw;
      repeat (8) @(posedge clk); // let the power filter settle
      bus(1'b1, 4'h0, start[7:0]);
      bus(1'b1, 4'h4, {3'b0, en[0], 1'b1, p[2:0]});
      t1 = tk;
      // run spans 3d+4 edges: a tick may land on the stop edge itself
      repeat (3 * d + 1) @(posedge clk);
      bus(1'b1, 4'h4, {3'b0, en[0], 1'b0, p[2:0]});
      g = tk - t1;
      inc = (pw == 2'b11) ? 0 : g / d;
      flag = (start + inc > 255);
      @(posedge clk); // a wrap on the stop edge shows one cycle later
      chk(wrap_irq, flag & en);
      bus(1'b0, 4'h0, 8'h00);
      chk(q, (start + inc) % 256);
      bus(1'b0, 4'h4, 8'h00);
      chk(q, flag * 32 + en * 16 + p);
      bus(1'b0, 4'h4, 8'h00);
      chk(q, en * 16 + p);
   endtask : run_case
   // ===========================================================
   // main sequence
   initial begin
      arst_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 4'h0;
      writedata = 32'h0;
      byteenable = 4'hF;
      cpu_pwr_state = 2'b00;
      mismatches = 0;
      comparisons = 0;
      cyc = 0;
      start = $urandom(32'h1951);
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      bus(1'b0, 4'h0, 8'h00);
      chk(q, 32'h0);
      bus(1'b0, 4'h4, 8'h00);
      chk(q, 32'h0);
      bus(1'b1, 4'h4, 8'hE7);
      bus(1'b0, 4'h4, 8'h00);
      chk(q, 32'h07);
      bus(1'b1, 4'h8, 8'hFF);
      bus(1'b0, 4'h8, 8'h00);
      chk(r, 2'b10);
      bus(1'b0, 4'h0, 8'h00);
      chk(q, 32'h0);
      // a write without lane 0 stores nothing
      byteenable <= 4'hE;
      bus(1'b1, 4'h0, 8'hA5);
      byteenable <= 4'hF;
      bus(1'b0, 4'h0, 8'h00);
      chk(q, 32'h0);
      // every prescale code, randomly in run or wait state
      for (int p = 0; p < 8; p++)
         run_case(p, ($urandom % 2) ? 2'b01 : 2'b00);
      run_case(3, 2'b11);
      // second reset in mid-run clears a loaded, enabled unit
      bus(1'b1, 4'h0, 8'h5A);
      bus(1'b1, 4'h4, 8'h1F);
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk(waitrequest, 1'b1);
      chk(wrap_irq, 1'b0);
      arst_n <= 1'b1;
      bus(1'b0, 4'h0, 8'h00);
      chk(q, 32'h0);
      bus(1'b0, 4'h4, 8'h00);
      chk(q, 32'h0);
      report_and_stop;
   end
endmodule : tb_top
